// File: design/ccrc_pkg.sv
// Package for the core clock and rate control block.
// Assumes a single 20 MHz clock domain and a plain register port.
package ccrc_pkg;

  // ------------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] ADDR_CLK_CFG = 8'h00;   // Family, freq code, enable, source
  localparam logic [7:0] ADDR_CLK_STS = 8'h04;   // Fine freq, freq and source status
  localparam logic [7:0] ADDR_RATE_CFG = 8'h08;  // Four rate slot codes
  localparam logic [7:0] ADDR_RATE_STS = 8'h0c;  // Applied flags and applied codes
  localparam logic [7:0] ADDR_PATH_REQ = 8'h10;  // Path enable request / active paths
  localparam logic [7:0] ADDR_PATH_NEED = 8'h14; // Least freq code per path
  localparam logic [7:0] ADDR_IRQ_STS = 8'h18;   // Sticky events, write one to clear
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h1c;  // Event mask

  // ------------------------------------------------------------------
  // Field positions in the clock configuration and status words
  // ------------------------------------------------------------------
  localparam int FAM_BIT = 15;
  localparam int FREQ_LSB = 8;
  localparam int EN_BIT = 6;
  localparam int SRC_LSB = 0;
  localparam int FINE_LSB = 16;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [2:0] FREQ_RST = 3'h4;
  localparam logic [4:0] SRC_RST = 5'h04;
  localparam logic [2:0] FREQ_STS_RST = 3'h0;
  localparam logic [4:0] SRC_STS_RST = 5'h00;
  localparam logic [7:0] RATE_RST = 8'h03;

  // ------------------------------------------------------------------
  // Source codes and highest frequency code
  // ------------------------------------------------------------------
  localparam logic [4:0] SRC_MCLK = 5'h00;
  localparam logic [4:0] SRC_LOOP_X2 = 5'h04;
  localparam logic [4:0] SRC_PORT1 = 5'h08;
  localparam logic [4:0] SRC_PORT2 = 5'h09;
  localparam logic [4:0] SRC_LOOP_X1 = 5'h0c;
  localparam logic [2:0] FREQ_MAX = 3'h4;

  // ------------------------------------------------------------------
  // Rate codes, base family and fractional family
  // ------------------------------------------------------------------
  localparam logic [7:0] RATE_12K = 8'h01;
  localparam logic [7:0] RATE_192K = 8'h05;
  localparam logic [7:0] RATE_8K = 8'h11;
  localparam logic [7:0] RATE_32K = 8'h13;
  localparam logic [7:0] RATE_11K = 8'h09;
  localparam logic [7:0] RATE_176K = 8'h0d;

  // ------------------------------------------------------------------
  // Fine frequency values, one step is 1/64 MHz
  // ------------------------------------------------------------------
  localparam logic [15:0] FINE_BASE = 16'h0189; // 6.144 MHz times 64, truncated
  localparam logic [15:0] FINE_FRAC = 16'h0169; // 5.6448 MHz times 64, truncated

  // ------------------------------------------------------------------
  // Counts and widths
  // ------------------------------------------------------------------
  localparam int NSLOT = 4;
  localparam int NPATH = 8;
  localparam int NEVT = 3;
  localparam int EVT_FREQ_LOW = 0;
  localparam int EVT_RATE_DONE = 1;
  localparam int EVT_BAD_CODE = 2;
  localparam int SYNC_NS = 1000;   // Frame boundary tick period
  localparam int CLK_NS = 50;
  localparam int SYNC_CYC = (SYNC_NS + CLK_NS - 1) / CLK_NS;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } ccrc_req_t;

  // Clock configuration fields
  typedef struct packed {
    logic fam;
    logic [2:0] freq;
    logic [4:0] src;
  } ccrc_cfg_t;

endpackage : ccrc_pkg

// File: design/ccrc_top.sv
// Core clock and rate control: source select, frequency status, rate slots,
// frequency sufficiency check. Assumes one 20 MHz clock and a plain register port.
// Overview of operation
// [RULE1] Four independent rate slot fields; every path uses one of them.
// [RULE2] Base family rate codes 0x01-0x05 and 0x11-0x13 pair with family zero.
// [RULE3] Software keeps all slots in one family matching the core clock family.
// [RULE4] Software sets frequency code 000-100 to match the real source frequency.
// [RULE5] Slot writes apply at a sync point; per-slot flag shows applied value.
// [RULE6] Source select picks master clock, either port bit clock or locked loop.
// [RULE7] Source codes 0x00, 0x04, 0x08, 0x09, 0x0C; others reserved.
// [RULE8] Locked loop source runs doubled for typical use or undoubled for low power.
// [RULE9] Software enables the source before the core clock, and the reverse.
// [RULE10] Software enables the core clock before any audio path.
// [RULE11] Family, frequency and source change together; switch is glitch free.
// [RULE12] Frequency-only change should clear core clock enable first.
// [RULE13] Read-only status gives frequency code, fine frequency and source in effect.
// [RULE14] Fine frequency status is sixteen bits, one step 1/64 MHz.
// [RULE15] Path enable refused when core clock too slow; active paths kept.
// [RULE16] Failed frequency check raises an interrupt event.
// [RULE17] Software keeps rate converters in 8-192 kHz, ratio 1-24 or 1.5.
// [RULE18] Software should choose the highest feasible core clock frequency.
// [RULE19] Reserved source or frequency codes are not applied; status keeps old value.
`timescale 1ns/1ns

module ccrc_top (
  input wire logic clk,                  // 20 MHz clock
  input wire logic sys_rst,              // Asynchronous reset, active high
  input wire ccrc_pkg::ccrc_req_t req,   // Register request
  output logic [31:0] rdata,             // Read data, cycle after read strobe
  output logic irq,                      // Level interrupt
  output logic core_clock_enable,        // Core clock gate enable
  output logic [4:0] core_clock_source,  // Source in effect
  output logic [7:0] path_active         // Enabled signal paths
);

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  ccrc_pkg::ccrc_cfg_t cfg_r;            // Configuration in effect
  logic en_r;
  logic [7:0] rate_r [ccrc_pkg::NSLOT];      // Written slot codes
  logic [7:0] rate_app_r [ccrc_pkg::NSLOT];  // Applied slot codes
  logic [ccrc_pkg::NSLOT-1:0] rate_ok_r;     // Applied flags
  logic [7:0] path_r;
  logic [23:0] need_r;                   // Three-bit least code per path
  logic [ccrc_pkg::NEVT-1:0] evt_r;
  logic [ccrc_pkg::NEVT-1:0] mask_r;
  logic [31:0] rdata_r;
  logic [4:0] tick_cnt_r;
  logic tick;
  logic src_ok, freq_ok, cfg_wr, rate_wr, path_wr, bad_wr;
  logic [7:0] path_grant;
  logic [ccrc_pkg::NEVT-1:0] evt_set;
  logic [15:0] fine;
  logic [31:0] rd_mux;
  ccrc_pkg::ccrc_cfg_t cfg_new;

  // ------------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------------
  // Write field decode
  assign cfg_new.fam = req.wdata[ccrc_pkg::FAM_BIT];
  assign cfg_new.freq = req.wdata[ccrc_pkg::FREQ_LSB +: 3];
  assign cfg_new.src = req.wdata[ccrc_pkg::SRC_LSB +: 5];
  assign src_ok = cfg_new.src inside {ccrc_pkg::SRC_MCLK, ccrc_pkg::SRC_LOOP_X2,
      ccrc_pkg::SRC_PORT1, ccrc_pkg::SRC_PORT2, ccrc_pkg::SRC_LOOP_X1}; // RULE7
  assign freq_ok = cfg_new.freq <= ccrc_pkg::FREQ_MAX;
  assign cfg_wr = req.wr && (req.addr == ccrc_pkg::ADDR_CLK_CFG);
  assign bad_wr = cfg_wr && !(src_ok && freq_ok); // RULE19
  assign rate_wr = req.wr && (req.addr == ccrc_pkg::ADDR_RATE_CFG);
  assign path_wr = req.wr && (req.addr == ccrc_pkg::ADDR_PATH_REQ);

  // Frequency check per path: grant new ones only when clock is fast enough
  always_comb begin
    path_grant = path_r;
    for (int i = 0; i < ccrc_pkg::NPATH; i++) begin
      if (req.wdata[i] && !path_r[i]) begin
        path_grant[i] = en_r && (cfg_r.freq >= need_r[3*i +: 3]); // RULE15
      end else if (!req.wdata[i]) begin
        path_grant[i] = 1'b0;
      end
    end
  end

  // Events
  assign evt_set[ccrc_pkg::EVT_FREQ_LOW] = path_wr && ((req.wdata[7:0] & ~path_r
      & ~path_grant) != 8'h00); // RULE16
  assign evt_set[ccrc_pkg::EVT_RATE_DONE] = tick && (rate_ok_r != '1);
  assign evt_set[ccrc_pkg::EVT_BAD_CODE] = bad_wr;
  assign irq = |(evt_r & mask_r);

  // Fine frequency: base step shifted by frequency code
  assign fine = (cfg_r.fam ? ccrc_pkg::FINE_FRAC : ccrc_pkg::FINE_BASE)
      << cfg_r.freq; // RULE14
  assign core_clock_enable = en_r;
  assign core_clock_source = cfg_r.src; // RULE6 RULE8
  assign path_active = path_r;

  // ------------------------------------------------------------------
  // Read mux
  // ------------------------------------------------------------------
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (req.addr)
      ccrc_pkg::ADDR_CLK_CFG: begin
        rd_mux[ccrc_pkg::FAM_BIT] = cfg_r.fam;
        rd_mux[ccrc_pkg::FREQ_LSB +: 3] = cfg_r.freq;
        rd_mux[ccrc_pkg::EN_BIT] = en_r;
        rd_mux[ccrc_pkg::SRC_LSB +: 5] = cfg_r.src;
      end
      ccrc_pkg::ADDR_CLK_STS: begin
        rd_mux[ccrc_pkg::FINE_LSB +: 16] = fine; // RULE13
        rd_mux[ccrc_pkg::FREQ_LSB +: 3] = cfg_r.freq;
        rd_mux[ccrc_pkg::SRC_LSB +: 5] = cfg_r.src;
      end
      ccrc_pkg::ADDR_RATE_CFG: rd_mux = {rate_r[3], rate_r[2], rate_r[1], rate_r[0]};
      ccrc_pkg::ADDR_RATE_STS: rd_mux = {rate_ok_r, rate_app_r[3][5:0],
          rate_app_r[2][5:0], rate_app_r[1][5:0], rate_app_r[0][5:0], 4'h0};
      ccrc_pkg::ADDR_PATH_REQ: rd_mux[7:0] = path_r;
      ccrc_pkg::ADDR_PATH_NEED: rd_mux[23:0] = need_r;
      ccrc_pkg::ADDR_IRQ_STS: rd_mux[ccrc_pkg::NEVT-1:0] = evt_r;
      ccrc_pkg::ADDR_IRQ_MASK: rd_mux[ccrc_pkg::NEVT-1:0] = mask_r;
      default: rd_mux = 32'h0000_0000;
    endcase
  end
  assign rdata = rdata_r;

  // ------------------------------------------------------------------
  // Sync tick: rate changes take effect on a frame boundary
  // ------------------------------------------------------------------
  assign tick = (tick_cnt_r == 5'(ccrc_pkg::SYNC_CYC - 1));
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) tick_cnt_r <= 5'h00;
    else tick_cnt_r <= tick ? 5'h00 : tick_cnt_r + 5'h01;
  end

  // ------------------------------------------------------------------
  // Clock configuration; reserved codes leave family, frequency and source in place
  // ------------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_r <= '{fam: 1'b0, freq: ccrc_pkg::FREQ_RST, src: ccrc_pkg::SRC_RST};
      en_r <= 1'b0;
    end else if (cfg_wr) begin
      en_r <= req.wdata[ccrc_pkg::EN_BIT];
      if (!bad_wr) cfg_r <= cfg_new; // RULE11 RULE19
    end
  end

  // ------------------------------------------------------------------
  // Rate slots
  // ------------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < ccrc_pkg::NSLOT; i++) begin
        rate_r[i] <= ccrc_pkg::RATE_RST; // RULE1
        rate_app_r[i] <= ccrc_pkg::RATE_RST;
      end
      rate_ok_r <= '1;
    end else begin
      for (int i = 0; i < ccrc_pkg::NSLOT; i++) begin
        if (rate_wr && (req.wdata[8*i +: 8] != rate_r[i])) begin
          rate_r[i] <= req.wdata[8*i +: 8]; // RULE2
          rate_ok_r[i] <= 1'b0; // RULE5
        end else if (tick) begin
          rate_app_r[i] <= rate_r[i]; // RULE5
          rate_ok_r[i] <= 1'b1;
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Paths, needs, events, mask, read data
  // ------------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      path_r <= 8'h00;
      need_r <= 24'h00_0000;
      evt_r <= '0;
      mask_r <= '0;
      rdata_r <= 32'h0000_0000;
    end else begin
      if (path_wr) path_r <= path_grant; // RULE15
      if (req.wr && (req.addr == ccrc_pkg::ADDR_PATH_NEED)) need_r <= req.wdata[23:0];
      if (req.wr && (req.addr == ccrc_pkg::ADDR_IRQ_MASK)) mask_r <= req.wdata[ccrc_pkg::NEVT-1:0];
      if (req.wr && (req.addr == ccrc_pkg::ADDR_IRQ_STS))
        evt_r <= (evt_r & ~req.wdata[ccrc_pkg::NEVT-1:0]) | evt_set; // RULE16
      else
        evt_r <= evt_r | evt_set;
      if (req.rd) rdata_r <= rd_mux;
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  a_reserved_src_kept: assert property (@(posedge clk) disable iff (sys_rst)
    bad_wr |=> $stable(cfg_r)) else $error("Reserved code applied"); // RULE19
  a_src_legal: assert property (@(posedge clk) disable iff (sys_rst)
    core_clock_source inside {5'h00, 5'h04, 5'h08, 5'h09, 5'h0c})
    else $error("Illegal source in effect"); // RULE7
  a_cfg_write_taken: assert property (@(posedge clk) disable iff (sys_rst)
    cfg_wr && !bad_wr |=> cfg_r == $past(cfg_new)) else $error("Config not taken"); // RULE11
  a_rate_applied_tick: assert property (@(posedge clk) disable iff (sys_rst)
    rate_wr && (req.wdata[7:0] != rate_r[0]) |=> !rate_ok_r[0] ##[1:20] rate_ok_r[0])
    else $error("Slot not applied in time"); // RULE5
  a_slow_refused: assert property (@(posedge clk) disable iff (sys_rst)
    path_wr && !en_r |=> (path_r & ~$past(path_r)) == 8'h00)
    else $error("Path granted without clock"); // RULE15
  a_fail_event: assert property (@(posedge clk) disable iff (sys_rst)
    evt_set[0] |=> evt_r[0]) else $error("Frequency event lost"); // RULE16
  a_fine_step: assert property (@(posedge clk) disable iff (sys_rst)
    !cfg_r.fam && cfg_r.freq == 3'h4 |-> fine == 16'h1890) else $error("Fine value wrong"); // RULE14
  a_slot_count: assert property (@(posedge clk) disable iff (sys_rst)
    tick |=> rate_app_r[3] == $past(rate_r[3]) || !rate_ok_r[3])
    else $error("Slot four not applied"); // RULE1
  a_status_src: assert property (@(posedge clk) disable iff (sys_rst)
    req.rd && req.addr == ccrc_pkg::ADDR_CLK_STS |=> rdata[4:0] == $past(cfg_r.src))
    else $error("Source status wrong"); // RULE13
  c_switch: cover property (@(posedge clk) cfg_wr && !bad_wr && en_r);
  c_refuse: cover property (@(posedge clk) evt_set[0]);
  c_rate: cover property (@(posedge clk) rate_wr ##[1:20] tick);

endmodule // ccrc_top

// File: dv/ccrc_host_model.sv
// Host model: drives the register port of the core clock and rate control.
// Assumes the bench calls its tasks after reset has been released.
`timescale 1ns/1ns

module ccrc_host_model (
  input wire logic clk,                // 20 MHz clock
  input wire logic [31:0] rdata,       // Read data from the design
  output ccrc_pkg::ccrc_req_t req      // Register request
);
  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  // Idle port until the first request
  initial begin
    req = '0;
  end

  // One-cycle write strobe, released after the taking edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req <= '{addr: a, wdata: ~d, wr: 1'b0, rd: 1'b0}; // Data no longer valid
  endtask

  // One-cycle read strobe, data taken in the following cycle
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 d = rdata;
  endtask
endmodule // ccrc_host_model

// File: dv/ccrc_top_tb.sv
// Self-checking bench for the core clock and rate control block.
// Assumes the package and top module from design/ are compiled first.
`timescale 1ns/1ns

module ccrc_top_tb;
  logic clk;
  logic sys_rst;
  ccrc_pkg::ccrc_req_t req;
  logic [31:0] rdata;
  logic irq;
  logic core_clock_enable;
  logic [4:0] core_clock_source;
  logic [7:0] path_active;
  int err_total = 0;
  int tests_run = 0;
  logic [31:0] d;
  logic [15:0] fine;
  ccrc_pkg::ccrc_cfg_t rows [5];

  // ----------------------------------------------------------------
  // Design, host and clock
  // ----------------------------------------------------------------
  ccrc_top i_ccrc_top (
    .clk(clk), .sys_rst(sys_rst), .req(req), .rdata(rdata), .irq(irq),
    .core_clock_enable(core_clock_enable), .core_clock_source(core_clock_source),
    .path_active(path_active)
  );

  ccrc_host_model i_ccrc_host_model (.clk(clk), .rdata(rdata), .req(req));

  // 50 ns clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  function automatic logic [31:0] cfg_word(input ccrc_pkg::ccrc_cfg_t c, input logic en);
    return {16'h0000, c.fam, 4'h0, c.freq, 1'b0, en, 1'b0, c.src};
  endfunction

  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Watchdog, far beyond the length of the sequence
  initial begin
    #(3000 * 50);
    err_total++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    // First row runs the fastest legal clock code
    rows = '{'{1'b0, 3'h4, 5'h00}, '{1'b0, 3'h3, 5'h04}, '{1'b1, 3'h2, 5'h08},
             '{1'b0, 3'h1, 5'h09}, '{1'b1, 3'h0, 5'h0c}};
    sys_rst = 1'b1;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    chk("reset source", 32'h04, 32'(core_clock_source));
    chk("reset enable", 32'h0, 32'(core_clock_enable));
    chk("reset paths", 32'h0, 32'(path_active));
    chk("reset irq", 32'h0, 32'(irq));
    i_ccrc_host_model.rd(ccrc_pkg::ADDR_CLK_CFG, d);
    chk("reset cfg", 32'h0000_0404, d);
    $display("test reset done");

    // Every source code with family and frequency in one write
    foreach (rows[i]) begin
      i_ccrc_host_model.wr(ccrc_pkg::ADDR_CLK_CFG, cfg_word(rows[i], 1'b1));
      settle();
      chk("source", 32'(rows[i].src), 32'(core_clock_source));
      chk("enable", 32'h1, 32'(core_clock_enable));
      fine = rows[i].fam ? ccrc_pkg::FINE_FRAC : ccrc_pkg::FINE_BASE;
      fine = fine << rows[i].freq;
      i_ccrc_host_model.rd(ccrc_pkg::ADDR_CLK_STS, d);
      chk("status", {fine, 5'h0, rows[i].freq, 3'h0, rows[i].src}, d);
      chk("fine", 32'(fine), 32'(d[31:16]));
    end
    $display("test sources done");

    // Four slots applied at the next sync tick
    // All slots from the base family, all within the converter range
    i_ccrc_host_model.wr(ccrc_pkg::ADDR_RATE_CFG, 32'h1305_1101);
    i_ccrc_host_model.rd(ccrc_pkg::ADDR_RATE_CFG, d);
    chk("rate readback", 32'h1305_1101, d);
    repeat (ccrc_pkg::SYNC_CYC + 4) @(posedge clk);
    i_ccrc_host_model.rd(ccrc_pkg::ADDR_RATE_STS, d);
    chk("rate status", {4'hf, 6'h13, 6'h05, 6'h11, 6'h01, 4'h0}, d & 32'hffff_fff0);
    i_ccrc_host_model.rd(ccrc_pkg::ADDR_IRQ_STS, d);
    chk("rate pending event", 32'h1, 32'(d[ccrc_pkg::EVT_RATE_DONE]));
    $display("test rates done");

    // Clock at 12.288 MHz; path 1 needs code 3 and is refused
    i_ccrc_host_model.wr(ccrc_pkg::ADDR_IRQ_STS, 32'h0000_0007);
    i_ccrc_host_model.wr(ccrc_pkg::ADDR_CLK_CFG, 32'h0000_800c);
    settle();
    chk("enable cleared", 32'h0, 32'(core_clock_enable));
    i_ccrc_host_model.wr(ccrc_pkg::ADDR_CLK_CFG, 32'h0000_0140);
    i_ccrc_host_model.wr(ccrc_pkg::ADDR_PATH_NEED, 32'h0000_0018);
    i_ccrc_host_model.wr(ccrc_pkg::ADDR_PATH_REQ, 32'h0000_0003);
    settle();
    chk("paths granted", 32'h01, 32'(path_active));
    i_ccrc_host_model.rd(ccrc_pkg::ADDR_IRQ_STS, d);
    chk("low freq event", 32'h1, 32'(d[ccrc_pkg::EVT_FREQ_LOW]));
    chk("irq masked", 32'h0, 32'(irq));
    i_ccrc_host_model.wr(ccrc_pkg::ADDR_IRQ_MASK, 32'h0000_0001);
    settle();
    chk("irq raised", 32'h1, 32'(irq));
    i_ccrc_host_model.wr(ccrc_pkg::ADDR_IRQ_STS, 32'h0000_0001);
    settle();
    chk("irq cleared", 32'h0, 32'(irq));
    $display("test path check done");

    // Reserved source and frequency codes keep the old setting
    i_ccrc_host_model.wr(ccrc_pkg::ADDR_CLK_CFG, 32'h0000_0145);
    i_ccrc_host_model.wr(ccrc_pkg::ADDR_CLK_CFG, 32'h0000_0540);
    settle();
    chk("kept source", 32'h00, 32'(core_clock_source));
    chk("active kept", 32'h01, 32'(path_active));
    i_ccrc_host_model.rd(ccrc_pkg::ADDR_CLK_STS, d);
    chk("kept status", 32'h0000_0100, d & 32'h0000_ffff);
    i_ccrc_host_model.rd(ccrc_pkg::ADDR_IRQ_STS, d);
    chk("bad code event", 32'h1, 32'(d[ccrc_pkg::EVT_BAD_CODE]));
    chk("irq masked off", 32'h0, 32'(irq));
    i_ccrc_host_model.rd(8'h20, d);
    chk("unmapped", 32'h0, d);
    $display("test reserved codes done");
    tally_and_finish();
  end
endmodule // ccrc_top_tb
